// *** src/psq_sequencer.sv ***
`timescale 1ns/1ps
`include "psq_defines.svh"
// Contract
// RULE1: program memory is 6K words; user code ends at 17fc and 17fd..17ff are reserved.
// RULE2: every reset kind loads the program counter with 0000 and defaults all registers; the code leaves the stack storage and pin synchroniser unreset.
// RULE3: cause flags read 1/0 after power-on, 0/0 after watchdog, 1/1 after pin reset.
// RULE4: interrupt service pushes the pc and continues at word 0008.
// RULE5: context save/restore copies accumulator and flags, minus cause flags, one level; the code drops a restore in the cycle after a table read.
// RULE6: table read addresses rom by middle:low index, low byte to acc, high to buffer.
// RULE7: low index increment wraps 0xff to 0x00 without touching the middle index.
// RULE8: adding acc to pc low byte carries into the pc high bits.
// RULE9: subtracting acc from pc low byte leaves the high bits on borrow.
// RULE10: with the high clock, instruction clock is high oscillator over 1, 2 or 4.
// RULE11: in slow mode the instruction clock is low oscillator over 4.
// RULE12: watchdog option is always-on, enabled (stops in sleep/green) or disabled.
// RULE13: reset pin option selects active reset or plain input bit without pull-up.
// RULE14: high clock option selects rc only, rc with 32768 Hz tick crystal, or crystal.
// RULE15: interrupt entry saves neither accumulator nor flags.
// RULE16: the return stack holds 8 levels.
// RULE17: return from interrupt pops the saved pc and resumes there.
module psq_sequencer (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire psq_pkg::psq_rst_cause_t rst_cause,
    input  wire logic                  reset_pin_n,
    input  wire logic                  op_valid,
    input  wire psq_pkg::psq_op_t      op,
    input  wire logic [12:0]           jump_addr,
    input  wire logic [7:0]            acc_in,
    input  wire logic [7:0]            flags_in,
    input  wire logic [15:0]           rom_data,
    input  wire psq_pkg::psq_cpu_div_t cpu_div_opt,
    input  wire psq_pkg::psq_wdt_mode_t wdt_mode_opt,
    input  wire psq_pkg::psq_hclk_src_t hclk_src_opt,
    input  wire logic                  reset_pin_is_reset,
    input  wire logic                  slow_mode,
    input  wire logic                  low_power_mode,
    output logic [12:0]                pc,
    output logic [12:0]                rom_addr,
    output logic                       rom_addr_reserved,
    output logic [7:0]                 acc_out,
    output logic                       acc_load,
    output logic [7:0]                 flags_out,
    output logic                       flags_load,
    output logic [7:0]                 read_buf,
    output logic [7:0]                 idx_mid,
    output logic [7:0]                 idx_low,
    output logic                       reset_cause_high_flag,
    output logic                       reset_cause_low_flag,
    output logic [2:0]                 stack_depth,
    output logic [1:0]                 cpu_div_sel,
    output logic                       wdt_running,
    output logic                       ext_reset_req,
    output logic                       port_bit_in,
    output logic                       osc_pins_gpio,
    output logic                       tick_xtal_en,
    output logic                       ext_xtal_en
);
    logic [12:0] pc_r;
    logic [12:0] rom_addr_r;
    logic        rom_addr_reserved_r;
    logic [7:0]  acc_out_r;
    logic        acc_load_r;
    logic [7:0]  flags_out_r;
    logic        flags_load_r;
    logic [7:0]  read_buf_r;
    logic [7:0]  idx_mid_r;
    logic [7:0]  idx_low_r;
    logic        flag_hi_r;
    logic        flag_lo_r;
    logic [7:0]  sh_acc_r;
    logic [7:0]  sh_flags_r;
    logic [1:0]  cpu_div_sel_r;
    logic        wdt_running_r;
    logic        ext_reset_req_r;
    logic        port_bit_in_r;
    logic        osc_pins_gpio_r;
    logic        tick_xtal_en_r;
    logic        ext_xtal_en_r;
    logic        pin_s1_r;
    logic        pin_s2_r;
    logic        tr_pend_r;
    logic [12:0] stk_top;
    logic [2:0]  stk_depth;
    logic        stk_push;
    logic        stk_pop;
    logic [8:0]  pcl_sum;
    logic [8:0]  pcl_diff;
    logic [12:0] idx_addr;

    wire do_op = op_valid & ~reset;
    assign stk_push = do_op & ((op == psq_pkg::PSQ_OP_CALL) | (op == psq_pkg::PSQ_OP_INT)); // RULE4
    assign stk_pop  = do_op & ((op == psq_pkg::PSQ_OP_RET) | (op == psq_pkg::PSQ_OP_RETURN_FROM_INTERRUPT)); // RULE17
    assign pcl_sum  = {1'b0, pc_r[7:0]} + {1'b0, acc_in};
    assign pcl_diff = {1'b0, pc_r[7:0]} - {1'b0, acc_in};
    // only 13 address bits exist, so the top of the middle index is dropped
    assign idx_addr = {idx_mid_r[4:0], idx_low_r}; // RULE6

    // 8-level return stack
    psq_ret_stack u_stack ( // RULE16
        .clk       (clk),
        .reset     (reset),
        .push      (stk_push),
        .pop       (stk_pop),
        .push_data (pc_r + 13'h1),
        .top_data  (stk_top),
        .depth     (stk_depth)
    );

    // program counter update
    always_ff @(posedge clk) begin
        if (reset) begin
            pc_r <= `PSQ_RESET_VEC; // RULE2
        end else if (op_valid) begin
            unique case (op)
                psq_pkg::PSQ_OP_JUMP, psq_pkg::PSQ_OP_CALL: begin
                    pc_r <= jump_addr;
                end
                psq_pkg::PSQ_OP_INT: begin
                    pc_r <= `PSQ_INT_VEC; // RULE4 RULE15
                end
                psq_pkg::PSQ_OP_RET, psq_pkg::PSQ_OP_RETURN_FROM_INTERRUPT: begin
                    pc_r <= stk_top; // RULE17
                end
                psq_pkg::PSQ_OP_ADD_PCL: begin
                    pc_r <= {pc_r[12:8] + {4'h0, pcl_sum[8]}, pcl_sum[7:0]}; // RULE8
                end
                psq_pkg::PSQ_OP_SUB_PCL: begin
                    pc_r <= {pc_r[12:8], pcl_diff[7:0]}; // RULE9
                end
                default: begin
                    pc_r <= pc_r + 13'h1;
                end
            endcase
        end
    end

    // table index, table read and its rom fetch
    always_ff @(posedge clk) begin
        if (reset) begin
            idx_mid_r           <= 8'h00;
            idx_low_r           <= 8'h00;
            rom_addr_r          <= `PSQ_RESET_VEC;
            rom_addr_reserved_r <= 1'b0;
            tr_pend_r           <= 1'b0;
            read_buf_r          <= 8'h00;
        end else begin
            tr_pend_r <= do_op & (op == psq_pkg::PSQ_OP_TABLE_READ);
            if (do_op && op == psq_pkg::PSQ_OP_INC_LOW_IDX) begin
                idx_low_r <= idx_low_r + 8'h01; // RULE7
            end
            // middle index moves only on its own op, never by a low-index carry
            if (do_op && op == psq_pkg::PSQ_OP_INC_MID_IDX) begin
                idx_mid_r <= idx_mid_r + 8'h01; // RULE7
            end
            rom_addr_r          <= (do_op && op == psq_pkg::PSQ_OP_TABLE_READ) ? idx_addr : pc_r;
            // reserved words above user code are flagged, not blocked
            rom_addr_reserved_r <= idx_addr > `PSQ_USER_END; // RULE1
            if (tr_pend_r) begin
                read_buf_r <= rom_data[15:8]; // RULE6
            end
        end
    end

    // accumulator / flag writeback from table read and context restore
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_out_r    <= 8'h00;
            acc_load_r   <= 1'b0;
            flags_out_r  <= `PSQ_FLAG_RST_VAL;
            flags_load_r <= 1'b0;
            sh_acc_r     <= 8'h00;
            sh_flags_r   <= `PSQ_FLAG_RST_VAL;
        end else begin
            acc_load_r   <= tr_pend_r | (do_op & (op == psq_pkg::PSQ_OP_POP_CTX));
            flags_load_r <= do_op & (op == psq_pkg::PSQ_OP_POP_CTX);
            if (tr_pend_r) begin
                acc_out_r <= rom_data[7:0]; // RULE6
            end else if (do_op && op == psq_pkg::PSQ_OP_POP_CTX) begin
                acc_out_r   <= sh_acc_r; // RULE5
                // cause flags are taken from the live copy, never from the shadow
                flags_out_r <= (sh_flags_r & `PSQ_FLAG_KEEP_MASK)
                             | {flag_hi_r, flag_lo_r, 6'h00}; // RULE5
            end
            if (do_op && op == psq_pkg::PSQ_OP_PUSH_CTX) begin
                sh_acc_r   <= acc_in; // RULE5
                sh_flags_r <= flags_in & `PSQ_FLAG_KEEP_MASK; // RULE5
            end
        end
    end

    // reset cause flags, loaded while reset is held
    always_ff @(posedge clk) begin
        if (reset) begin
            unique case (rst_cause)
                psq_pkg::PSQ_RST_WATCHDOG: begin
                    flag_hi_r <= 1'b0; // RULE3
                    flag_lo_r <= 1'b0;
                end
                psq_pkg::PSQ_RST_PIN: begin
                    flag_hi_r <= 1'b1; // RULE3
                    flag_lo_r <= 1'b1;
                end
                default: begin
                    flag_hi_r <= 1'b1; // RULE3
                    flag_lo_r <= 1'b0;
                end
            endcase
        end
    end

    // shared reset pin synchroniser
    always_ff @(posedge clk) begin
        pin_s1_r <= reset_pin_n;
        pin_s2_r <= pin_s1_r;
    end

    // option decode
    always_ff @(posedge clk) begin
        if (reset) begin
            cpu_div_sel_r   <= 2'h0;
            wdt_running_r   <= 1'b0;
            ext_reset_req_r <= 1'b0;
            port_bit_in_r   <= 1'b0;
            osc_pins_gpio_r <= 1'b0;
            tick_xtal_en_r  <= 1'b0;
            ext_xtal_en_r   <= 1'b0;
        end else begin
            // select encodes 1/2/4 as 0/1/2; slow mode forces low osc over 4
            if (slow_mode) begin
                cpu_div_sel_r <= 2'h3; // RULE11
            end else begin
                cpu_div_sel_r <= cpu_div_opt; // RULE10
            end
            wdt_running_r <= (wdt_mode_opt == psq_pkg::PSQ_WDT_ALWAYS)
                           | ((wdt_mode_opt == psq_pkg::PSQ_WDT_ENABLE) & ~low_power_mode); // RULE12
            ext_reset_req_r <= reset_pin_is_reset & ~pin_s2_r; // RULE13
            port_bit_in_r   <= ~reset_pin_is_reset & pin_s2_r; // RULE13
            osc_pins_gpio_r <= hclk_src_opt == psq_pkg::PSQ_HCLK_RC_ONLY; // RULE14
            tick_xtal_en_r  <= hclk_src_opt == psq_pkg::PSQ_HCLK_RC_TICK; // RULE14
            ext_xtal_en_r   <= hclk_src_opt == psq_pkg::PSQ_HCLK_XTAL; // RULE14
        end
    end

    assign pc                    = pc_r;
    assign rom_addr              = rom_addr_r;
    assign rom_addr_reserved     = rom_addr_reserved_r;
    assign acc_out               = acc_out_r;
    assign acc_load              = acc_load_r;
    assign flags_out             = flags_out_r;
    assign flags_load            = flags_load_r;
    assign read_buf              = read_buf_r;
    assign idx_mid               = idx_mid_r;
    assign idx_low               = idx_low_r;
    assign reset_cause_high_flag = flag_hi_r;
    assign reset_cause_low_flag  = flag_lo_r;
    assign stack_depth           = stk_depth;
    assign cpu_div_sel           = cpu_div_sel_r;
    assign wdt_running           = wdt_running_r;
    assign ext_reset_req         = ext_reset_req_r;
    assign port_bit_in           = port_bit_in_r;
    assign osc_pins_gpio         = osc_pins_gpio_r;
    assign tick_xtal_en          = tick_xtal_en_r;
    assign ext_xtal_en           = ext_xtal_en_r;
endmodule : psq_sequencer

// *** shared/psq_defines.svh ***
`ifndef PSQ_DEFINES_SVH
`define PSQ_DEFINES_SVH
`define PSQ_ROM_WORDS      6144
`define PSQ_USER_END       13'h17fc
`define PSQ_ROM_LAST       13'h17ff
`define PSQ_RESET_VEC      13'h0000
`define PSQ_INT_VEC        13'h0008
`define PSQ_STACK_DEPTH    8
`define PSQ_FLAG_HI_BIT    7
`define PSQ_FLAG_LO_BIT    6
`define PSQ_FLAG_KEEP_MASK 8'h3f
`define PSQ_FLAG_RST_VAL   8'h00
`endif

// *** shared/psq_pkg.sv ***
package psq_pkg;
    typedef enum logic [1:0] {
        PSQ_RST_POWER,
        PSQ_RST_WATCHDOG,
        PSQ_RST_PIN
    } psq_rst_cause_t;
    typedef enum logic [1:0] {
        PSQ_DIV_1,
        PSQ_DIV_2,
        PSQ_DIV_4
    } psq_cpu_div_t;
    typedef enum logic [1:0] {
        PSQ_WDT_ALWAYS,
        PSQ_WDT_ENABLE,
        PSQ_WDT_DISABLE
    } psq_wdt_mode_t;
    typedef enum logic [1:0] {
        PSQ_HCLK_RC_ONLY,
        PSQ_HCLK_RC_TICK,
        PSQ_HCLK_XTAL
    } psq_hclk_src_t;
    typedef enum logic [3:0] {
        PSQ_OP_STEP,
        PSQ_OP_JUMP,
        PSQ_OP_CALL,
        PSQ_OP_RET,
        PSQ_OP_RETURN_FROM_INTERRUPT,
        PSQ_OP_INT,
        PSQ_OP_ADD_PCL,
        PSQ_OP_SUB_PCL,
        PSQ_OP_TABLE_READ,
        PSQ_OP_PUSH_CTX,
        PSQ_OP_POP_CTX,
        PSQ_OP_INC_LOW_IDX,
        PSQ_OP_INC_MID_IDX
    } psq_op_t;
endpackage : psq_pkg

// *** src/psq_ret_stack.sv ***
`timescale 1ns/1ps
`include "psq_defines.svh"
module psq_ret_stack (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        push,
    input  wire logic        pop,
    input  wire logic [12:0] push_data,
    output logic      [12:0] top_data,
    output logic      [2:0]  depth
);
    logic [12:0] mem_r [0:`PSQ_STACK_DEPTH-1];
    logic [2:0]  ptr_r;
    // pointer wraps silently, as the real stack gives no overflow flag
    always_ff @(posedge clk) begin
        if (reset) begin
            ptr_r <= 3'h0;
        end else if (push) begin
            ptr_r <= ptr_r + 3'h1;
        end else if (pop) begin
            ptr_r <= ptr_r - 3'h1;
        end
    end
    // storage needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[ptr_r] <= push_data;
        end
    end
    assign top_data = mem_r[ptr_r - 3'h1];
    assign depth    = ptr_r;
endmodule : psq_ret_stack

// *** verification/psq_sequencer_assertions.sv ***
`timescale 1ns/1ps
module psq_sequencer_assertions (
    input wire logic                    clk,
    input wire logic                    reset,
    input wire psq_pkg::psq_rst_cause_t rst_cause,
    input wire logic                    op_valid,
    input wire psq_pkg::psq_op_t        op,
    input wire logic [12:0]             jump_addr,
    input wire logic [7:0]              acc_in,
    input wire logic [15:0]             rom_data,
    input wire logic                    slow_mode,
    input wire logic [12:0]             pc,
    input wire logic [12:0]             rom_addr,
    input wire logic                    rom_addr_reserved,
    input wire logic [7:0]              acc_out,
    input wire logic                    acc_load,
    input wire logic [7:0]              read_buf,
    input wire logic [7:0]              idx_mid,
    input wire logic [7:0]              idx_low,
    input wire logic                    reset_cause_high_flag,
    input wire logic                    reset_cause_low_flag,
    input wire logic [2:0]              stack_depth,
    input wire logic [1:0]              cpu_div_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // first edge out of reset sees the vector and the cause flags
    a_reset_pc_zero:
    assert property ($fell(reset) |-> pc == 13'h0000) else $error("pc not at reset vector");
    a_cause_flags:
    assert property ($fell(reset) |-> {reset_cause_high_flag, reset_cause_low_flag} ==
        (($past(rst_cause) == psq_pkg::PSQ_RST_POWER) ? 2'b10 :
        ($past(rst_cause) == psq_pkg::PSQ_RST_WATCHDOG) ? 2'b00 : 2'b11))
        else $error("reset cause flags wrong");
    // flow changes, one edge after the op is taken
    a_int_vector:
    assert property (op_valid && op == psq_pkg::PSQ_OP_INT |=> pc == 13'h0008 &&
        stack_depth == $past(stack_depth) + 3'h1) else $error("interrupt entry wrong");
    a_call_push:
    assert property (op_valid && op == psq_pkg::PSQ_OP_CALL |=> pc == $past(jump_addr) &&
        stack_depth == $past(stack_depth) + 3'h1) else $error("call push wrong");
    a_add_carry:
    assert property (op_valid && op == psq_pkg::PSQ_OP_ADD_PCL |=>
        pc == $past(pc) + {5'h00, $past(acc_in)}) else $error("computed jump wrong");
    a_sub_no_borrow:
    assert property (op_valid && op == psq_pkg::PSQ_OP_SUB_PCL |=>
        pc[12:8] == 5'($past(pc) >> 8) && pc[7:0] == 8'($past(pc) - {5'h00, $past(acc_in)}))
        else $error("borrow reached pc high bits");
    // table read: address one edge, data the edge after
    a_table_path:
    assert property (op_valid && op == psq_pkg::PSQ_OP_TABLE_READ |=>
        rom_addr == 13'({$past(idx_mid), $past(idx_low)}) ##1 acc_load &&
        acc_out == 8'($past(rom_data)) && read_buf == 8'($past(rom_data) >> 8))
        else $error("table read wrong");
    a_low_wrap:
    assert property (op_valid && op == psq_pkg::PSQ_OP_INC_LOW_IDX |=>
        idx_low == $past(idx_low) + 8'h01 && $stable(idx_mid)) else $error("index step wrong");
    a_slow_div:
    assert property (slow_mode |=> cpu_div_sel == 2'h3) else $error("slow divider wrong");
    a_mid_step:
    assert property (op_valid && op == psq_pkg::PSQ_OP_INC_MID_IDX |=>
        idx_mid == $past(idx_mid) + 8'h01 && $stable(idx_low))
        else $error("middle index step wrong");
    // words above the last user word are flagged one edge after the index points there
    a_reserved_flag:
    assert property (rom_addr_reserved == ($past({idx_mid[4:0], idx_low}) > 13'h17fc))
        else $error("reserved flag wrong");
    cover property (rom_addr_reserved);
    cover property (op_valid && op == psq_pkg::PSQ_OP_TABLE_READ);
    cover property (op_valid && op == psq_pkg::PSQ_OP_RETURN_FROM_INTERRUPT);
    cover property ($fell(reset) && reset_cause_low_flag);
endmodule : psq_sequencer_assertions

bind psq_sequencer psq_sequencer_assertions chk_i (.*);

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    typedef struct {
        psq_pkg::psq_op_t o;
        logic [12:0]      j;
        logic [7:0]       a;
        logic [12:0]      pc_e;
        logic [2:0]       dep_e;
    } psq_row_t;
    logic clk = 1'b0, reset = 1'b1, reset_pin_n = 1'b1, op_valid = 1'b0, reset_pin_is_reset = 1'b0;
    logic slow_mode = 1'b0, low_power_mode = 1'b0;
    psq_pkg::psq_rst_cause_t rst_cause = psq_pkg::PSQ_RST_POWER;
    psq_pkg::psq_op_t        op = psq_pkg::PSQ_OP_STEP;
    psq_pkg::psq_cpu_div_t   cpu_div_opt = psq_pkg::PSQ_DIV_1;
    psq_pkg::psq_wdt_mode_t  wdt_mode_opt = psq_pkg::PSQ_WDT_ALWAYS;
    psq_pkg::psq_hclk_src_t  hclk_src_opt = psq_pkg::PSQ_HCLK_RC_ONLY;
    logic [12:0] jump_addr = 13'h0000, pc, rom_addr;
    logic [7:0]  acc_in = 8'h00, flags_in = 8'hff, acc_out, flags_out, read_buf, idx_mid, idx_low;
    logic [15:0] rom_data;
    logic [2:0]  stack_depth;
    logic [1:0]  cpu_div_sel;
    logic rom_addr_reserved, acc_load, flags_load, reset_cause_high_flag, reset_cause_low_flag;
    logic wdt_running, ext_reset_req, port_bit_in, osc_pins_gpio, tick_xtal_en, ext_xtal_en;
    int   fail_count = 0, num_checks = 0;
    psq_row_t rows[9] = '{
        '{psq_pkg::PSQ_OP_JUMP, 13'h10ff, 8'h00, 13'h10ff, 3'h0},
        '{psq_pkg::PSQ_OP_ADD_PCL, 13'h0000, 8'h01, 13'h1100, 3'h0},
        '{psq_pkg::PSQ_OP_SUB_PCL, 13'h0000, 8'h01, 13'h11ff, 3'h0},
        '{psq_pkg::PSQ_OP_ADD_PCL, 13'h0000, 8'h10, 13'h120f, 3'h0},
        '{psq_pkg::PSQ_OP_CALL, 13'h0400, 8'h00, 13'h0400, 3'h1},
        '{psq_pkg::PSQ_OP_INT, 13'h0000, 8'h00, 13'h0008, 3'h2},
        '{psq_pkg::PSQ_OP_STEP, 13'h0000, 8'h00, 13'h0009, 3'h2},
        '{psq_pkg::PSQ_OP_RETURN_FROM_INTERRUPT, 13'h0000, 8'h00, 13'h0401, 3'h1},
        '{psq_pkg::PSQ_OP_RET, 13'h0000, 8'h00, 13'h1210, 3'h0}};
    logic [1:0] cause_exp[3] = '{2'b10, 2'b00, 2'b11};

    psq_sequencer uut (.*);
    // rom image: word depends on the low address byte so a wrong low index shows up
    assign rom_data = {~rom_addr[7:0], rom_addr[7:0] ^ 8'h3c};
    always #10 clk = ~clk;

    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    // op_valid stays high so back-to-back ops need no gap
    task automatic do_op(input psq_pkg::psq_op_t o, input logic [12:0] j, input logic [7:0] a);
        op_valid = 1'b1;
        op = o;
        jump_addr = j;
        acc_in = a;
        tick();
    endtask : do_op
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // hang guard: whole sequence needs well under 2000 cycles
    initial begin
        #100000;
        fail_count++;
        final_report();
    end

    initial begin
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        tick();
        chk(16'({reset_cause_high_flag, reset_cause_low_flag}), 16'h0002);
        foreach (rows[i]) begin
            do_op(rows[i].o, rows[i].j, rows[i].a);
            chk(16'(pc), 16'(rows[i].pc_e));
            chk(16'(stack_depth), 16'(rows[i].dep_e));
        end
        // fill all eight levels, pointer wraps, then unwind in order
        do_op(psq_pkg::PSQ_OP_JUMP, 13'h0000, 8'h00);
        for (int k = 1; k <= 8; k++) begin
            do_op(psq_pkg::PSQ_OP_CALL, 13'(k * 256), 8'h00);
            chk(16'(stack_depth), 16'(k & 7));
        end
        for (int k = 8; k >= 1; k--) begin
            do_op(psq_pkg::PSQ_OP_RET, 13'h0000, 8'h00);
            chk(16'(pc), 16'((k - 1) * 256 + 1));
        end
        repeat (255) do_op(psq_pkg::PSQ_OP_INC_LOW_IDX, 13'h0000, 8'h00);
        do_op(psq_pkg::PSQ_OP_TABLE_READ, 13'h0000, 8'h00);
        chk(16'(rom_addr), 16'h00ff);
        do_op(psq_pkg::PSQ_OP_INC_LOW_IDX, 13'h0000, 8'h00);
        chk({read_buf, acc_out}, 16'h00c3);
        chk(16'(acc_load), 16'h0001);
        chk({idx_mid, idx_low}, 16'h0000);
        // shadow save, interrupt entry touches neither acc nor flags, restore keeps live cause flags
        do_op(psq_pkg::PSQ_OP_PUSH_CTX, 13'h0000, 8'ha5);
        do_op(psq_pkg::PSQ_OP_INT, 13'h0000, 8'h00);
        chk(16'({acc_load, flags_load}), 16'h0000);
        flags_in = 8'h40;
        do_op(psq_pkg::PSQ_OP_POP_CTX, 13'h0000, 8'h00);
        // cause bits come from the live reset-cause flags (power-on: 1/0), not from flags_in
        chk({acc_out, flags_out}, 16'ha5bf);
        chk(16'({acc_load, flags_load}), 16'h0003);
        op_valid = 1'b0;
        for (int i = 0; i < 3; i++) begin
            cpu_div_opt = psq_pkg::psq_cpu_div_t'(i);
            wdt_mode_opt = psq_pkg::psq_wdt_mode_t'(i);
            hclk_src_opt = psq_pkg::psq_hclk_src_t'(i);
            low_power_mode = 1'b1;
            slow_mode = 1'b0;
            repeat (2) tick();
            chk(16'(cpu_div_sel), 16'(i));
            chk(16'(wdt_running), 16'(i == 0));
            chk(16'({osc_pins_gpio, tick_xtal_en, ext_xtal_en}), 16'(3'b100 >> i));
            low_power_mode = 1'b0;
            slow_mode = 1'b1;
            repeat (2) tick();
            chk(16'(wdt_running), 16'(i != 2));
            chk(16'(cpu_div_sel), 16'h0003);
        end
        slow_mode = 1'b0;
        // every reset cause, each from a nonzero pc
        for (int i = 0; i < 3; i++) begin
            do_op(psq_pkg::PSQ_OP_JUMP, 13'h0123, 8'h00);
            op_valid = 1'b0;
            reset = 1'b1;
            rst_cause = psq_pkg::psq_rst_cause_t'(i);
            repeat (2) tick();
            reset = 1'b0;
            tick();
            chk(16'(pc), 16'h0000);
            chk(16'({reset_cause_high_flag, reset_cause_low_flag}), 16'(cause_exp[i]));
        end
        // index walks to the last user word, then one past it into the reserved area
        repeat (23) do_op(psq_pkg::PSQ_OP_INC_MID_IDX, 13'h0000, 8'h00);
        repeat (252) do_op(psq_pkg::PSQ_OP_INC_LOW_IDX, 13'h0000, 8'h00);
        chk({idx_mid, idx_low}, 16'h17fc);
        do_op(psq_pkg::PSQ_OP_TABLE_READ, 13'h0000, 8'h00);
        chk(16'({rom_addr_reserved, rom_addr}), 16'h17fc);
        do_op(psq_pkg::PSQ_OP_INC_LOW_IDX, 13'h0000, 8'h00);
        do_op(psq_pkg::PSQ_OP_TABLE_READ, 13'h0000, 8'h00);
        chk(16'({rom_addr_reserved, rom_addr}), 16'h37fd);
        op_valid = 1'b0;
        // shared pin as plain input, then as reset input
        reset_pin_n = 1'b0;
        repeat (4) tick();
        chk(16'({ext_reset_req, port_bit_in}), 16'h0000);
        reset_pin_n = 1'b1;
        repeat (4) tick();
        chk(16'({ext_reset_req, port_bit_in}), 16'h0001);
        reset_pin_is_reset = 1'b1;
        reset_pin_n = 1'b0;
        repeat (4) tick();
        chk(16'(ext_reset_req), 16'h0001);
        final_report();
    end
endmodule : tb_top
